// file: rtl/tdm_align_pkg.sv
// Constants and register map for the frame alignment and offset block
// Summary of operation
// - Output frame pulses track master frame pulse
// - Data of frame N leaves in N+2
// - Width bit picks single or double pulses
// - Polarity bits pick input and output edges
// - Discriminator off after reset, on when enabled
// - Mode 000 low jitter, 111 both
// - Other modes reserved; mode ignored when disabled
// - Default sampling 3/4; software may choose 1/2
// - Per-stream input delay, quarter bits up to 7 3/4
// - Sample mode low: field is quarter-bit delay
// - Sample mode high: low bits pick sample point
// - Sample mode high: upper bits whole-bit delay
// - Per-stream output advancement setting
// - Advance 0, 2, 4, 6 fast cycles
// - Detect pulse style, mirror it on outputs
// - Input polarity default falling, rising for alternate
package tdm_align_pkg;
  localparam int STREAMS = 64;
  localparam int HALF_STREAMS = 32;
  localparam int EDGES_PER_FRAME = 1024;
  localparam int FRAME_CNT_W = 10;
  localparam int FRAME_OFFSET_EDGES = 1;
  localparam int WIN_LOW_FREQ = 4;
  localparam int WIN_HIGH_FREQ = 1;
  localparam int LONG_RUN_EDGES = 8;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 9'h000;
  localparam logic [ADDR_W-1:0] STAT_OFS = 9'h001;
  localparam logic [3:0] REGION_MISC = 4'h0;
  localparam logic [3:0] REGION_LID = 4'h8;
  localparam logic [3:0] REGION_BID = 4'h9;
  localparam logic [3:0] REGION_LOA = 4'ha;
  localparam logic [3:0] REGION_BOA = 4'hb;
  localparam int CTRL_FPW_BIT = 0;
  localparam int CTRL_IPOL_BIT = 1;
  localparam int CTRL_OPOL_BIT = 2;
  localparam int CTRL_DEN_BIT = 3;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_SMPL_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] MODE_LOW_ONLY = 3'h0;
  localparam logic [2:0] MODE_LOW_HIGH = 3'h7;
  localparam logic [5:0] DEFAULT_SAMPLE_Q = 6'h03;
  localparam logic [5:0] SMP_CODE0_Q = 6'h03;
  localparam logic [5:0] SMP_CODE1_Q = 6'h04;
  localparam logic [5:0] SMP_CODE2_Q = 6'h01;
  localparam logic [5:0] SMP_CODE3_Q = 6'h02;
  localparam logic [4:0] DELAY_RESET = 5'h00;
  localparam logic [1:0] ADV_RESET = 2'h0;
  localparam real FAST_CLK_MHZ = 131.072;
  localparam int ADV_STEP_CYCLES = 2;
  localparam logic [1:0] BANK_LAST = 2'h2;
endpackage

// file: rtl/offset_if.sv
// Per-stream offset settings and their decoded values
`timescale 1ns/1ps
`default_nettype none
interface offset_if;
  logic sample_mode;
  logic [4:0] in_field [64];
  logic [1:0] adv_code [64];
  logic [5:0] in_quarters [64];
  logic [2:0] adv_cycles [64];
  modport ctrl (output sample_mode, output in_field, output adv_code,
    input in_quarters, input adv_cycles);
  modport calc (input sample_mode, input in_field, input adv_code,
    output in_quarters, output adv_cycles);
endinterface
`default_nettype wire

// file: rtl/stream_offset_calc.sv
// Decodes per-stream delay and advancement codes
`timescale 1ns/1ps
`default_nettype none
module stream_offset_calc (
  offset_if.calc ofs
);
  import tdm_align_pkg::*;
  for (genvar s = 0; s < STREAMS; s++) begin : g_stream
    logic [5:0] point_q;
    always_comb begin
      case (ofs.in_field[s][1:0])
        2'b00: point_q = SMP_CODE0_Q;
        2'b01: point_q = SMP_CODE1_Q;
        2'b10: point_q = SMP_CODE2_Q;
        default: point_q = SMP_CODE3_Q;
      endcase
    end
    // Quarter bits measured from frame boundary, 3/4 is nominal
    always_comb begin
      if (ofs.sample_mode) begin
        ofs.in_quarters[s] = {1'b0, ofs.in_field[s][4:2], 2'b00}
          + point_q;
      end else begin
        ofs.in_quarters[s] = {1'b0, ofs.in_field[s]}
          + DEFAULT_SAMPLE_Q;
      end
    end
    assign ofs.adv_cycles[s] = {ofs.adv_code[s], 1'b0};
  end
endmodule
`default_nettype wire

// file: rtl/tdm_frame_align.sv
// Frame timing, pulse style detection and per-stream offsets
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tdm_frame_align #(
  parameter int EDGES = tdm_align_pkg::EDGES_PER_FRAME,
  parameter int OFFSET = tdm_align_pkg::FRAME_OFFSET_EDGES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_master_clock_in,
  input wire logic i_master_frame_pulse_in,
  input wire logic [tdm_align_pkg::ADDR_W-1:0] i_addr,
  input wire logic [tdm_align_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [tdm_align_pkg::DATA_W-1:0] o_rd_data,
  output logic o_generated_frame_pulse_8m,
  output logic o_generated_frame_pulse_16m,
  output logic o_clock_out,
  output logic o_frame_boundary,
  output logic [1:0] o_wr_bank,
  output logic [1:0] o_rd_bank,
  output logic [63:0][5:0] o_in_quarters,
  output logic [63:0][2:0] o_adv_cycles
);
  import tdm_align_pkg::*;

  localparam logic [FRAME_CNT_W-1:0] LAST_CNT = FRAME_CNT_W'(EDGES - 1);
  localparam logic [FRAME_CNT_W-1:0] OFS_CNT = FRAME_CNT_W'(OFFSET);

  offset_if ofs ();

  logic [7:0] ctrl_r;
  logic [4:0] lid_r [HALF_STREAMS];
  logic [4:0] bid_r [HALF_STREAMS];
  logic [1:0] loa_r [HALF_STREAMS];
  logic [1:0] boa_r [HALF_STREAMS];
  logic clk_s1_r, clk_s2_r, clk_s3_r;
  logic fp_s1_r, fp_s2_r;
  logic act_edge;
  logic last_lvl_r;
  logic [3:0] run_r;
  logic prev_long_r;
  logic gci_r;
  logic pulse_evt;
  logic [FRAME_CNT_W-1:0] cnt_r;
  logic locked_r;
  logic near;
  logic accept;
  logic pulse_on_r;
  logic pulse_w_r;
  logic [1:0] wr_bank_r;
  logic [3:0] region;
  logic [4:0] idx;
  logic [DATA_W-1:0] rd_nxt;
  logic dbl_w, ipol, opol, disc_en, smpl;
  logic [2:0] mode;

  assign dbl_w = ctrl_r[CTRL_FPW_BIT];
  assign ipol = ctrl_r[CTRL_IPOL_BIT];
  assign opol = ctrl_r[CTRL_OPOL_BIT];
  assign disc_en = ctrl_r[CTRL_DEN_BIT];
  assign mode = ctrl_r[CTRL_MODE_LSB+2:CTRL_MODE_LSB];
  assign smpl = ctrl_r[CTRL_SMPL_BIT];
  assign region = i_addr[ADDR_W-1:5];
  assign idx = i_addr[4:0];

  // Register writes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= CTRL_RESET;
    end else if (i_wr && i_addr == CTRL_OFS) begin
      ctrl_r <= i_wr_data[7:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < HALF_STREAMS; i++) begin
        lid_r[i] <= DELAY_RESET;
        bid_r[i] <= DELAY_RESET;
        loa_r[i] <= ADV_RESET;
        boa_r[i] <= ADV_RESET;
      end
    end else if (i_wr) begin
      case (region)
        REGION_LID: lid_r[idx] <= i_wr_data[4:0];
        REGION_BID: bid_r[idx] <= i_wr_data[4:0];
        REGION_LOA: loa_r[idx] <= i_wr_data[1:0];
        REGION_BOA: boa_r[idx] <= i_wr_data[1:0];
        default: ;
      endcase
    end
  end

  // Read data stand in the cycle after the strobe only
  always_comb begin
    rd_nxt = '0;
    case (region)
      REGION_MISC: begin
        if (i_addr == CTRL_OFS) begin
          rd_nxt = {8'h00, ctrl_r};
        end else if (i_addr == STAT_OFS) begin
          rd_nxt = {12'h000, wr_bank_r, locked_r, gci_r};
        end
      end
      REGION_LID: rd_nxt = {11'h000, lid_r[idx]};
      REGION_BID: rd_nxt = {11'h000, bid_r[idx]};
      REGION_LOA: rd_nxt = {14'h0000, loa_r[idx]};
      REGION_BOA: rd_nxt = {14'h0000, boa_r[idx]};
      default: rd_nxt = '0;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= '0;
    end else if (i_rd) begin
      o_rd_data <= rd_nxt;
    end else begin
      o_rd_data <= '0;
    end
  end

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
      fp_s1_r <= 1'b1;
      fp_s2_r <= 1'b1;
    end else begin
      clk_s1_r <= i_master_clock_in;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      fp_s1_r <= i_master_frame_pulse_in;
      fp_s2_r <= fp_s1_r;
    end
  end

  // Falling edge by default, rising when the polarity bit is set
  assign act_edge = ipol ? (clk_s2_r & ~clk_s3_r)
                         : (~clk_s2_r & clk_s3_r);

  // Style detection: the pulse is the short run after a long one
  assign pulse_evt = act_edge && (fp_s2_r != last_lvl_r) && prev_long_r
    && (run_r <= (dbl_w ? 4'h2 : 4'h1));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      last_lvl_r <= 1'b1;
      run_r <= 4'h0;
      prev_long_r <= 1'b0;
    end else if (act_edge) begin
      if (fp_s2_r != last_lvl_r) begin
        last_lvl_r <= fp_s2_r;
        run_r <= 4'h1;
        prev_long_r <= (run_r > 4'(LONG_RUN_EDGES));
      end else if (run_r != 4'hf) begin
        run_r <= run_r + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gci_r <= 1'b0;
    end else if (pulse_evt) begin
      gci_r <= last_lvl_r;
    end
  end

  // Discriminator window around the expected boundary
  always_comb begin
    if (mode == MODE_LOW_HIGH) begin
      near = (cnt_r >= LAST_CNT - FRAME_CNT_W'(WIN_HIGH_FREQ))
        || (cnt_r < FRAME_CNT_W'(WIN_HIGH_FREQ));
    end else begin
      // Reserved codes fall back to the low-frequency window
      near = (cnt_r >= LAST_CNT - FRAME_CNT_W'(WIN_LOW_FREQ))
        || (cnt_r < FRAME_CNT_W'(WIN_LOW_FREQ));
    end
  end

  // A pulse far from the flywheel is ignored once locked, while the discriminator is enabled
  assign accept = pulse_evt && (!disc_en || !locked_r || near);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= '0;
      locked_r <= 1'b0;
    end else if (accept) begin
      cnt_r <= '0;
      locked_r <= 1'b1;
    end else if (act_edge) begin
      cnt_r <= (cnt_r == LAST_CNT) ? '0 : cnt_r + FRAME_CNT_W'(1);
    end
  end

  // Output pulse starts a fixed number of edges after the boundary
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pulse_on_r <= 1'b0;
      pulse_w_r <= 1'b0;
    end else if (act_edge && locked_r && cnt_r == OFS_CNT) begin
      pulse_on_r <= 1'b1;
      pulse_w_r <= dbl_w;
    end else if (act_edge && pulse_on_r) begin
      pulse_on_r <= pulse_w_r;
      pulse_w_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_generated_frame_pulse_8m <= 1'b1;
      o_generated_frame_pulse_16m <= 1'b1;
      o_clock_out <= 1'b0;
      o_frame_boundary <= 1'b0;
    end else begin
      o_generated_frame_pulse_8m <= gci_r ? pulse_on_r : ~pulse_on_r;
      o_generated_frame_pulse_16m <= gci_r ? pulse_on_r : ~pulse_on_r;
      o_clock_out <= clk_s3_r ^ opol;
      o_frame_boundary <= act_edge && cnt_r == LAST_CNT;
    end
  end

  // Three banks: written in N, idle in N+1, read in N+2
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_bank_r <= 2'h0;
    end else if (act_edge && cnt_r == LAST_CNT && !accept) begin
      wr_bank_r <= (wr_bank_r == BANK_LAST) ? 2'h0 : wr_bank_r + 2'h1;
    end else if (accept && locked_r) begin
      wr_bank_r <= (wr_bank_r == BANK_LAST) ? 2'h0 : wr_bank_r + 2'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wr_bank <= 2'h0;
      o_rd_bank <= 2'h1;
    end else begin
      o_wr_bank <= wr_bank_r;
      o_rd_bank <= (wr_bank_r == BANK_LAST) ? 2'h0 : wr_bank_r + 2'h1;
    end
  end

  // Stream settings to the decoder, decoded values registered out
  assign ofs.sample_mode = smpl;
  for (genvar s = 0; s < HALF_STREAMS; s++) begin : g_map
    assign ofs.in_field[s] = lid_r[s];
    assign ofs.in_field[s + HALF_STREAMS] = bid_r[s];
    assign ofs.adv_code[s] = loa_r[s];
    assign ofs.adv_code[s + HALF_STREAMS] = boa_r[s];
  end

  stream_offset_calc u_calc (
    .ofs(ofs)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_in_quarters <= '{default: DEFAULT_SAMPLE_Q};
      o_adv_cycles <= '0;
    end else begin
      for (int s = 0; s < STREAMS; s++) begin
        o_in_quarters[s] <= ofs.in_quarters[s];
        o_adv_cycles[s] <= ofs.adv_cycles[s];
      end
    end
  end

  // Counts the edges that a pulse has stood, so that its width can be
  // bounded without a long repetition in a sequence
  logic [1:0] on_edges_r;
  logic one_wide_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      on_edges_r <= 2'h0;
      one_wide_r <= 1'b0;
    end else if (act_edge && locked_r && cnt_r == OFS_CNT) begin
      on_edges_r <= 2'h0;
      one_wide_r <= !dbl_w;
    end else if (act_edge && pulse_on_r && on_edges_r != 2'h3) begin
      on_edges_r <= on_edges_r + 2'h1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence pulse_start_s;
    act_edge && locked_r && cnt_r == OFS_CNT;
  endsequence

  sequence accepted_s;
    accept;
  endsequence

  pulse_start_a: assert property (
    pulse_start_s |=> pulse_on_r)
    else $error("pulse did not start at offset");

  boundary_reset_a: assert property (
    accepted_s |=> cnt_r == '0)
    else $error("frame count not cleared on boundary");

  single_width_a: assert property (
    one_wide_r && on_edges_r != 2'h0 |-> !pulse_on_r)
    else $error("single pulse lasted too long");

  disc_off_a: assert property (
    !disc_en |-> accept == pulse_evt)
    else $error("pulse dropped while discriminator off");

  far_pulse_a: assert property (
    disc_en && locked_r && pulse_evt && !near |=> !$past(accept))
    else $error("far pulse accepted");

  bank_step_a: assert property (
    act_edge && cnt_r == LAST_CNT && !accept |=> wr_bank_r !=
      $past(wr_bank_r))
    else $error("bank did not advance at frame end");

  bank_pair_a: assert property (
    ##1 o_rd_bank != o_wr_bank && o_rd_bank <= BANK_LAST)
    else $error("read and write banks collide");

  idle_level_a: assert property (
    !pulse_on_r |=> o_generated_frame_pulse_8m == !$past(gci_r))
    else $error("idle pulse level wrong for style");

  adv_even_a: assert property (
    o_adv_cycles[0][0] == 1'b0 && o_adv_cycles[63][0] == 1'b0)
    else $error("odd advancement count");

  delay_map_a: assert property (
    !smpl && !$changed(lid_r[0]) ##1 !$changed(lid_r[0])
      |-> o_in_quarters[0] == {1'b0, lid_r[0]} + DEFAULT_SAMPLE_Q)
    else $error("fractional delay decode wrong");

  read_ctrl_a: assert property (
    i_rd && i_addr == CTRL_OFS && !i_wr |=>
      o_rd_data == {8'h00, $past(ctrl_r)})
    else $error("control readback wrong");

endmodule
`default_nettype wire

// file: tb/timing_master.sv
// Master clock and frame pulse source facing the alignment block
`timescale 1ns/1ps
`default_nettype none
module timing_master #(
  parameter int EDGES = 32,
  parameter int HALF_NS = 60
) (
  input wire logic i_dbl,
  input wire logic i_alt,
  input wire logic i_rise,
  input wire logic i_stray,
  output logic o_clk,
  output logic o_fp
);
  int cnt;
  logic stray_done;
  logic act;

  // Clock runs free, as a timing master's clock does between frames
  initial begin
    o_clk = 1'b0;
    o_fp = 1'b1;
    cnt = 0;
    stray_done = 1'b0;
    forever begin
      #HALF_NS;
      o_clk = ~o_clk;
      if (o_clk == i_rise) begin
        cnt = (cnt + 1) % EDGES;
      end else begin
        // Pulse moves half a period before the edge that samples it
        act = (cnt == EDGES - 1) || (i_dbl && cnt == EDGES - 2);
        if (i_stray && !stray_done && cnt == EDGES / 2) begin
          act = 1'b1;
          stray_done = 1'b1;
        end
        if (!i_stray) begin
          stray_done = 1'b0;
        end
        o_fp = act ? i_alt : ~i_alt;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tdm_frame_align_bench.sv
// Self-checking bench for the frame alignment and offset block
`timescale 1ns/1ps
`default_nettype none
module tdm_frame_align_bench;
  import tdm_align_pkg::*;
  localparam int EDGES = 32;
  localparam int MPER = 6;
  localparam int FRAME = EDGES * MPER;
  localparam int SMP [4] = '{3, 4, 1, 2};
  localparam logic [8:0] OADDR [4] = '{9'h100, 9'h11f, 9'h120, 9'h13f};
  localparam int OIDX [4] = '{0, 31, 32, 63};
  localparam int OVAL [4] = '{0, 31, 5, 18};
  logic i_clk, i_rst, i_wr, i_rd;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wr_data, o_rd_data;
  logic fp8, fp16, clk_out, fb, co;
  logic [1:0] wr_bank, rd_bank, bk0, bk1;
  logic [63:0][5:0] quarters;
  logic [63:0][2:0] adv;
  logic dbl, alt, rise, stray, mclk, mfp;
  int miscompares, n_checks, lag, wid, tot, nfb;

  timing_master #(.EDGES(EDGES), .HALF_NS(MPER * 10)) master (
    .i_dbl(dbl), .i_alt(alt), .i_rise(rise), .i_stray(stray),
    .o_clk(mclk), .o_fp(mfp));

  tdm_frame_align #(.EDGES(EDGES), .OFFSET(1)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_master_clock_in(mclk),
    .i_master_frame_pulse_in(mfp), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
    .o_rd_data(o_rd_data), .o_generated_frame_pulse_8m(fp8),
    .o_generated_frame_pulse_16m(fp16), .o_clock_out(clk_out),
    .o_frame_boundary(fb), .o_wr_bank(wr_bank), .o_rd_bank(rd_bank),
    .o_in_quarters(quarters), .o_adv_cycles(adv));

  task automatic final_report();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic near(input int seen, input int exp, input int tol);
    check(32'(seen >= exp - tol && seen <= exp + tol), 32'h1);
  endtask

  function automatic logic [15:0] cv(input logic d, input logic ip,
    input logic op, input logic en, input logic [2:0] m, input logic s);
    cv = '0;
    cv[CTRL_FPW_BIT] = d;
    cv[CTRL_IPOL_BIT] = ip;
    cv[CTRL_OPOL_BIT] = op;
    cv[CTRL_DEN_BIT] = en;
    cv[CTRL_MODE_LSB +: 3] = m;
    cv[CTRL_SMPL_BIT] = s;
  endfunction

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rd_data;
  endtask

  // Every wait is bounded so a dead frame timer cannot hang the run
  task automatic wait_for(input bit sel, input logic val, output int n);
    n = 0;
    while ((sel ? mfp : fp8) !== val) begin
      @(posedge i_clk);
      #1;
      n++;
      if (fb === 1'b1) begin
        nfb++;
      end
      if (n > 4000) begin
        miscompares++;
        final_report();
      end
    end
  endtask

  // Times one output pulse: lag behind master, width, start to start
  task automatic measure(input bit with_master);
    int n, p;
    if (with_master) begin
      wait_for(1, ~alt, n);
      wait_for(1, alt, n);
    end
    wait_for(0, alt, lag);
    nfb = 0;
    co = clk_out;
    bk0 = wr_bank;
    check(fp16, fp8);
    wait_for(0, ~alt, wid);
    wait_for(0, alt, p);
    bk1 = wr_bank;
    tot = wid + p;
  endtask

  task automatic t_reset();
    logic [15:0] d;
    #1;
    check(quarters[0], 6'h03);
    check(quarters[63], 6'h03);
    check(adv[40], 3'h0);
    check(wr_bank, 2'h0);
    check(rd_bank, 2'h1);
    check(fp8, 1'b1);
    rd(CTRL_OFS, d);
    check(d, 16'h0000);
    rd(9'h1ff, d);
    check(d, 16'h0000);
  endtask

  task automatic t_offsets();
    logic [15:0] d;
    wr(CTRL_OFS, cv(0, 0, 0, 0, 3'h0, 0));
    for (int k = 0; k < 4; k++) begin
      wr(OADDR[k], 16'(OVAL[k]));
      rd(OADDR[k], d);
      check(d, 16'(OVAL[k]));
      check(quarters[OIDX[k]], 32'(OVAL[k] + 3));
    end
    wr(CTRL_OFS, cv(0, 0, 0, 0, 3'h0, 1));
    for (int c = 0; c < 4; c++) begin
      wr(9'h13f, 16'(28 + c));
      wr(9'h140, 16'(c));
      wr(9'h17f, 16'(c));
      repeat (2) @(posedge i_clk);
      #1;
      check(quarters[63], 32'(28 + SMP[c]));
      check(adv[0], 32'(2 * c));
      check(adv[63], 32'(2 * c));
    end
    wr(CTRL_OFS, cv(0, 0, 0, 0, 3'h0, 0));
  endtask

  task automatic t_frame(input logic d, input logic a);
    logic [15:0] st;
    logic c0;
    int l0;
    dbl <= d;
    alt <= a;
    rise <= a;
    wr(CTRL_OFS, cv(d, a, 0, 0, 3'h0, 0));
    repeat (3) measure(1);
    l0 = lag;
    c0 = co;
    measure(1);
    near(wid, MPER * (d ? 2 : 1), 2);
    near(tot, FRAME, 2);
    near(lag, l0, 1);
    check(nfb, 1);
    check(bk1, 32'((bk0 + 1) % 3));
    check(rd_bank, 32'((bk1 + 1) % 3));
    rd(STAT_OFS, st);
    check(st[0], a);
    wr(CTRL_OFS, cv(d, a, 1, 0, 3'h0, 0));
    measure(1);
    check(co, !c0);
  endtask

  // A stray master pulse mid-frame; a locked discriminator ignores it
  task automatic t_discr(input logic en, input logic [2:0] m);
    alt <= 1'b0;
    rise <= 1'b0;
    dbl <= 1'b0;
    wr(CTRL_OFS, cv(0, 0, 0, en, m, 0));
    repeat (3) measure(1);
    repeat ((EDGES / 2 + 4) * MPER) @(posedge i_clk);
    stray <= 1'b1;
    measure(0);
    stray <= 1'b0;
    if (en) begin
      near(tot, FRAME, 2);
    end else begin
      check(32'(tot < FRAME - 40), 32'h1);
    end
  endtask

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  initial begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wr_data = '0;
    dbl = 1'b0;
    alt = 1'b0;
    rise = 1'b0;
    stray = 1'b0;
    miscompares = 0;
    n_checks = 0;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_offsets();
    t_frame(0, 0);
    t_frame(1, 0);
    t_frame(0, 1);
    t_discr(1, 3'h7);
    t_discr(1, 3'h0);
    t_discr(1, 3'h5);
    t_discr(0, 3'h7);
    final_report();
  end
endmodule
`default_nettype wire
